// ===== pkg/i2c_timing_pkg.sv
// shared constants for the i2c data timing and address accept block
package i2c_timing_pkg;
    // ==========================================
    // field widths
    localparam int TIMING_PRESCALER_W = 4;
    localparam int HOLD_W = 4;
    localparam int SETUP_W = 4;
    localparam int DNF_W = 4;
    // ==========================================
    // synchroniser and fixed latencies in kernel cycles
    localparam int SYNC_STAGES = 2;
    localparam int HOLD_EXTRA_CYCLES = 1;
    // ==========================================
    // clock figures
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
    // ==========================================
    // special address headers, upper seven bits, broadcast as a full byte
    localparam logic [6:0] ADDR_ALERT_RESP = 7'h0C;
    localparam logic [6:0] ADDR_DEV_DEFAULT = 7'h61;
    localparam logic [6:0] ADDR_HOST = 7'h08;
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    // ==========================================
    // reset values of every enable and of the filter counter
    localparam logic CFG_RESET = 1'b0;
    localparam logic [3:0] CNT_RESET = 4'h0;
    // ==========================================
    // buffer geometry
    localparam int BUF_DEPTH = 2;
    localparam int BUF_W = 8;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HOLD  = 2'b01,
        ST_WAIT  = 2'b10,
        ST_SETUP = 2'b11
    } seq_state_t;
endpackage : i2c_timing_pkg

// ===== hw/sync_filter.sv
// two-stage synchroniser followed by a programmable digital filter
`timescale 1ns/1ps
`default_nettype none
module sync_filter
    import i2c_timing_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // pin and filter length
    input wire logic pin_i,
    input wire logic [DNF_W-1:0] noise_filter_length_i,
    // filtered level
    output logic level_o
);
    logic meta_reg;
    logic sync_reg;
    logic [DNF_W-1:0] cnt_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b1;
            cnt_reg <= CNT_RESET;
        end else if (sync_reg == level_o) begin
            cnt_reg <= CNT_RESET;
        end else if (cnt_reg >= noise_filter_length_i) begin
            level_o <= sync_reg;
            cnt_reg <= CNT_RESET;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : sync_filter
`default_nettype wire

// ===== hw/skid_buffer.sv
// two-entry valid/ready buffer for transmit bytes
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [2];
    logic wr_reg;
    logic rd_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    // handshake terms
    assign in_ready_o = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_reg];

    // storage and pointers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cnt_reg <= 2'h0;
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data_i;
                wr_reg <= ~wr_reg;
            end
            if (pop) begin
                rd_reg <= ~rd_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : skid_buffer
`default_nettype wire

// ===== hw/i2c_data_timing.sv
// data hold and setup timing plus special address acceptance
//
// Function
// - hold delay before driving data after fall
// - clock synchroniser adds two to three cycles
// - noise filter delays by length cycles
// - hold clock low for setup time
// - stretch clock low to meet setup
// - checksum enable stored and read back, no checksum calculation here
// - absent features read zero, ignore writes
// - device alert drives pin, accepts header
// - host alert selects pin; else gpio free
// - default address accepted when enabled
// - host address accepted when enabled
// - broadcast call accepted when enabled
// - wakeup settable only with zero filter
// - stretch disable writable only when disabled
// - slave byte control enable in slave
`timescale 1ns/1ps
`default_nettype none
module i2c_data_timing
    import i2c_timing_pkg::*;
#(
    parameter bit HAS_SMBUS = 1'b1,
    parameter bit HAS_WAKEUP = 1'b1
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // timing settings
    input wire logic [TIMING_PRESCALER_W-1:0] timing_prescaler_i,
    input wire logic [HOLD_W-1:0] hold_delay_count_i,
    input wire logic [SETUP_W-1:0] setup_delay_count_i,
    input wire logic [DNF_W-1:0] noise_filter_length_i,
    // configuration write port
    input wire logic cfg_we_i,
    input wire logic checksum_enable_i,
    input wire logic alert_enable_i,
    input wire logic default_addr_enable_i,
    input wire logic host_addr_enable_i,
    input wire logic broadcast_call_enable_i,
    input wire logic stop_wakeup_enable_i,
    input wire logic stretch_disable_i,
    input wire logic slave_byte_ctrl_i,
    input wire logic peripheral_enable_i,
    input wire logic slave_role_i,
    // configuration readback
    output logic checksum_enable_o,
    output logic alert_enable_o,
    output logic default_addr_enable_o,
    output logic host_addr_enable_o,
    output logic broadcast_call_enable_o,
    output logic stop_wakeup_enable_o,
    output logic stretch_disable_o,
    output logic slave_byte_ctrl_o,
    // transmit data stream
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [BUF_W-1:0] tx_data_i,
    output logic [BUF_W-1:0] tx_byte_o,
    // address check
    input wire logic [7:0] addr_byte_i,
    output logic addr_match_o,
    // bus pins, oe low means driving
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic alert_pin_o,
    output logic alert_pin_oe_n_o,
    output logic alert_gpio_free_o,
    output logic alert_input_en_o,
    // timing status
    output logic data_driven_o,
    output logic setup_done_o
);
    // ==========================================
    // configuration register
    logic chk_reg;
    logic alrt_reg;
    logic ddef_reg;
    logic host_reg;
    logic bcast_reg;
    logic wup_reg;
    logic nostr_reg;
    logic sbc_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            chk_reg <= CFG_RESET;
            alrt_reg <= CFG_RESET;
            ddef_reg <= CFG_RESET;
            host_reg <= CFG_RESET;
            bcast_reg <= CFG_RESET;
            wup_reg <= CFG_RESET;
            nostr_reg <= CFG_RESET;
            sbc_reg <= CFG_RESET;
        end else if (cfg_we_i) begin
            chk_reg <= checksum_enable_i & HAS_SMBUS;
            alrt_reg <= alert_enable_i & HAS_SMBUS;
            ddef_reg <= default_addr_enable_i & HAS_SMBUS;
            host_reg <= host_addr_enable_i & HAS_SMBUS;
            bcast_reg <= broadcast_call_enable_i;
            if (noise_filter_length_i == CNT_RESET || !stop_wakeup_enable_i) begin
                wup_reg <= stop_wakeup_enable_i & HAS_WAKEUP;
            end
            if (!peripheral_enable_i) begin
                nostr_reg <= stretch_disable_i;
            end
            sbc_reg <= slave_byte_ctrl_i;
        end
    end

    // readback of stored settings
    assign checksum_enable_o = chk_reg;
    assign alert_enable_o = alrt_reg;
    assign default_addr_enable_o = ddef_reg;
    assign host_addr_enable_o = host_reg;
    assign broadcast_call_enable_o = bcast_reg;
    assign stop_wakeup_enable_o = wup_reg;
    assign stretch_disable_o = nostr_reg;
    assign slave_byte_ctrl_o = sbc_reg;

    // ==========================================
    // alert pin and address match
    logic dev_role;
    assign dev_role = !host_reg;
    assign alert_pin_o = 1'b0;
    assign alert_pin_oe_n_o = !(alrt_reg && dev_role);
    // host alert input and gpio release
    assign alert_input_en_o = alrt_reg && host_reg;
    assign alert_gpio_free_o = !alrt_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            addr_match_o <= 1'b0;
        end else begin
            addr_match_o <= (alrt_reg && dev_role && addr_byte_i[7:1] == ADDR_ALERT_RESP)
                || (ddef_reg && addr_byte_i[7:1] == ADDR_DEV_DEFAULT)
                || (host_reg && addr_byte_i[7:1] == ADDR_HOST)
                || (bcast_reg && addr_byte_i == ADDR_BROADCAST);
        end
    end

    // ==========================================
    // clock input conditioning
    logic scl_flt;
    logic scl_prev_reg;
    logic scl_fall;

    sync_filter u_scl_filter (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .pin_i(scl_i),
        .noise_filter_length_i(noise_filter_length_i),
        .level_o(scl_flt)
    );

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scl_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_flt;
        end
    end
    assign scl_fall = scl_prev_reg && !scl_flt;

    // ==========================================
    // transmit buffer
    logic buf_valid;
    logic buf_ready;
    logic [BUF_W-1:0] buf_data;

    skid_buffer #(.WIDTH(BUF_W)) u_tx_buf (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready),
        .out_data_o(buf_data)
    );

    // ==========================================
    // prescaler tick
    logic [TIMING_PRESCALER_W-1:0] pre_reg;
    logic tick;
    logic pre_run;
    assign tick = pre_run && (pre_reg == timing_prescaler_i);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !pre_run) begin
            pre_reg <= '0;
        end else if (tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 4'h1;
        end
    end

    // ==========================================
    // hold and setup sequencer
    seq_state_t state_reg;
    logic [SETUP_W:0] cnt_reg;
    logic stretch_ok;
    assign stretch_ok = !(nostr_reg && slave_role_i);
    // prescaler idles in the extra hold cycle so setup starts on a fresh period
    assign pre_run = (state_reg == ST_HOLD && cnt_reg != '0) || (state_reg == ST_SETUP);
    // pop on the extra hold cycle, or as soon as a stretched wait sees data
    assign buf_ready = buf_valid && ((state_reg == ST_HOLD && cnt_reg == '0)
        || state_reg == ST_WAIT);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (scl_fall) begin
                        // one kernel cycle then hold count ticks
                        state_reg <= ST_HOLD;
                        cnt_reg <= {1'b0, hold_delay_count_i};
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg != '0) begin
                        if (tick) begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end
                    end else begin
                        // count spent: one more kernel cycle, then data
                        // wait for data when stretching
                        state_reg <= (buf_valid || !stretch_ok) ? ST_SETUP : ST_WAIT;
                        cnt_reg <= {1'b0, setup_delay_count_i} + 5'h01;
                    end
                end
                ST_WAIT: begin
                    if (buf_valid) begin
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        if (cnt_reg == 5'h01) begin
                            state_reg <= ST_IDLE;
                            cnt_reg <= '0;
                        end else begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // driven data byte and setup pulse
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_byte_o <= '1; // data line released after reset
            data_driven_o <= 1'b0;
            setup_done_o <= 1'b0;
        end else begin
            data_driven_o <= buf_ready;
            if (buf_ready) begin
                tx_byte_o <= buf_data;
            end
            setup_done_o <= (state_reg == ST_SETUP) && tick && cnt_reg == 5'h01;
        end
    end

    // clock held low while waiting or in setup
    assign scl_o = 1'b0;
    assign scl_oe_n_o = !(stretch_ok && (state_reg == ST_WAIT || state_reg == ST_SETUP));
    assign sda_o = tx_byte_o[7];
    assign sda_oe_n_o = tx_byte_o[7];

    // ==========================================
    // checks
    chk_lock_stretch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        peripheral_enable_i |=> $stable(nostr_reg)) else $error("stretch bit changed");
    chk_wakeup_filter: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(wup_reg) |-> $past(noise_filter_length_i) == 4'h0)
        else $error("wakeup set with filter");
    chk_smbus_absent: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !HAS_SMBUS |-> !(chk_reg || alrt_reg || ddef_reg || host_reg))
        else $error("smbus bit set");
    chk_alert_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        alrt_reg && !host_reg |-> !alert_pin_oe_n_o) else $error("alert not driven");
    chk_bcast_match: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        addr_byte_i == 8'h00 |=> addr_match_o == $past(bcast_reg))
        else $error("broadcast match wrong");
    chk_hold_entry: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_reg == ST_IDLE && scl_fall |=> state_reg == ST_HOLD)
        else $error("hold not started");
    chk_sync_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        noise_filter_length_i == 4'h0 && $fell(scl_flt) |-> $past(scl_i, 3) == 1'b0)
        else $error("sync latency wrong");
    chk_wait_pop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_reg == ST_WAIT && buf_valid |=> data_driven_o) else $error("wait byte not taken");
    chk_setup_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_reg == ST_SETUP && stretch_ok |-> !scl_oe_n_o) else $error("scl released early");
    chk_reset_clear: assert property (@(posedge mclk_i)
        !rst_n_i |=> !chk_reg && !bcast_reg && !sbc_reg) else $error("enable not cleared");
    cov_hold_setup: cover property (@(posedge mclk_i) disable iff (!rst_n_i) setup_done_o);
    cov_wait_data: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_reg == ST_WAIT ##1 state_reg == ST_SETUP);
    cov_addr_hit: cover property (@(posedge mclk_i) disable iff (!rst_n_i) addr_match_o);
endmodule : i2c_data_timing
`default_nettype wire

// ===== verif/bus_node_model.sv
// far-side bus node that pulls the clock line low on request
`timescale 1ns/1ps
`default_nettype none
module bus_node_model #(
    parameter int LOW_CYCLES = 48
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // request and device drive
    input wire logic fall_req_i,
    input wire logic scl_oe_n_i,
    // resolved clock line
    output logic scl_line_o
);
    logic [7:0] low_cnt_reg;
    // ==========================================
    // low period, long enough to cover a whole sequence
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            low_cnt_reg <= 8'h00;
        end else if (fall_req_i) begin
            low_cnt_reg <= 8'(LOW_CYCLES);
        end else if (low_cnt_reg != 8'h00) begin
            low_cnt_reg <= low_cnt_reg - 8'h01;
        end
    end
    // wired and with pull-up, released line reads high
    assign scl_line_o = (low_cnt_reg == 8'h00) && scl_oe_n_i;
endmodule : bus_node_model
`default_nettype wire

// ===== verif/i2c_data_timing_and_address_accept_test.sv
// self-checking bench for the data timing and address accept block
`timescale 1ns/1ps
`default_nettype none
module i2c_data_timing_and_address_accept_test;
    import i2c_timing_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, cfg_we_i = 1'b0, peripheral_enable_i = 1'b0;
    logic slave_role_i = 1'b1, tx_valid_i = 1'b0, fall_req = 1'b0;
    logic [3:0] timing_prescaler_i = 4'h0, hold_delay_count_i = 4'h0;
    logic [3:0] setup_delay_count_i = 4'h0, noise_filter_length_i = 4'h0;
    logic [7:0] cfg_in = 8'h00, tx_data_i = 8'h00, addr_byte_i = 8'hFF, cfg_exp = 8'h00;
    logic [7:0] cfg_rb, tx_byte_o, b0;
    logic checksum_enable_o, alert_enable_o, default_addr_enable_o, host_addr_enable_o;
    logic broadcast_call_enable_o, stop_wakeup_enable_o, stretch_disable_o, slave_byte_ctrl_o;
    logic tx_ready_o, addr_match_o, scl_i, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
    logic alert_pin_o, alert_pin_oe_n_o, alert_gpio_free_o, alert_input_en_o;
    logic data_driven_o, setup_done_o;
    wire [7:0] min_rb;
    logic [7:0] probes [9] = '{8'h00, 8'h01, 8'h18, 8'h19, 8'hC2, 8'hC3, 8'h10, 8'h11, 8'h5A};
    int seed, failures = 0, num_checks = 0, cycles = 0, i, j;

    // ==========================================
    // design, far-side node and clock
    i2c_data_timing uut (
        .mclk_i, .rst_n_i, .timing_prescaler_i, .hold_delay_count_i, .setup_delay_count_i,
        .noise_filter_length_i, .cfg_we_i, .checksum_enable_i(cfg_in[7]),
        .alert_enable_i(cfg_in[6]), .default_addr_enable_i(cfg_in[5]),
        .host_addr_enable_i(cfg_in[4]), .broadcast_call_enable_i(cfg_in[3]),
        .stop_wakeup_enable_i(cfg_in[2]), .stretch_disable_i(cfg_in[1]),
        .slave_byte_ctrl_i(cfg_in[0]), .peripheral_enable_i, .slave_role_i,
        .checksum_enable_o, .alert_enable_o, .default_addr_enable_o, .host_addr_enable_o,
        .broadcast_call_enable_o, .stop_wakeup_enable_o, .stretch_disable_o,
        .slave_byte_ctrl_o, .tx_valid_i, .tx_ready_o, .tx_data_i, .tx_byte_o, .addr_byte_i,
        .addr_match_o, .scl_i, .scl_o, .scl_oe_n_o, .sda_o, .sda_oe_n_o, .alert_pin_o,
        .alert_pin_oe_n_o, .alert_gpio_free_o, .alert_input_en_o, .data_driven_o,
        .setup_done_o
    );
    bus_node_model #(.LOW_CYCLES(48)) partner (
        .mclk_i, .rst_n_i, .fall_req_i(fall_req), .scl_oe_n_i(scl_oe_n_o), .scl_line_o(scl_i)
    );
    // reduced build without the optional bus features
    i2c_data_timing #(.HAS_SMBUS(1'b0), .HAS_WAKEUP(1'b0)) uut_min (
        .mclk_i, .rst_n_i, .timing_prescaler_i, .hold_delay_count_i, .setup_delay_count_i,
        .noise_filter_length_i, .cfg_we_i, .checksum_enable_i(cfg_in[7]),
        .alert_enable_i(cfg_in[6]), .default_addr_enable_i(cfg_in[5]),
        .host_addr_enable_i(cfg_in[4]), .broadcast_call_enable_i(cfg_in[3]),
        .stop_wakeup_enable_i(cfg_in[2]), .stretch_disable_i(cfg_in[1]),
        .slave_byte_ctrl_i(cfg_in[0]), .peripheral_enable_i, .slave_role_i,
        .checksum_enable_o(min_rb[7]), .alert_enable_o(min_rb[6]),
        .default_addr_enable_o(min_rb[5]), .host_addr_enable_o(min_rb[4]),
        .broadcast_call_enable_o(min_rb[3]), .stop_wakeup_enable_o(min_rb[2]),
        .stretch_disable_o(min_rb[1]), .slave_byte_ctrl_o(min_rb[0]), .tx_valid_i(1'b0),
        .tx_ready_o(), .tx_data_i(8'h00), .tx_byte_o(), .addr_byte_i, .addr_match_o(),
        .scl_i(1'b1), .scl_o(), .scl_oe_n_o(), .sda_o(), .sda_oe_n_o(), .alert_pin_o(),
        .alert_pin_oe_n_o(), .alert_gpio_free_o(), .alert_input_en_o(), .data_driven_o(),
        .setup_done_o()
    );
    assign cfg_rb = {checksum_enable_o, alert_enable_o, default_addr_enable_o,
        host_addr_enable_o, broadcast_call_enable_o, stop_wakeup_enable_o,
        stretch_disable_o, slave_byte_ctrl_o};
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    // ==========================================
    // expectation helpers
    function automatic logic [7:0] next_cfg(input logic [7:0] old, input logic [7:0] wr,
        input logic pe_now, input logic [3:0] flt);
        logic [7:0] n;
        n = wr;
        if (wr[2] && flt != 4'h0) n[2] = old[2];
        if (pe_now) n[1] = old[1];
        return n;
    endfunction : next_cfg
    function automatic logic addr_hit(input logic [7:0] c, input logic [7:0] a);
        return (c[6] && !c[4] && a[7:1] == 7'h0C) || (c[5] && a[7:1] == 7'h61)
            || (c[4] && a[7:1] == 7'h08) || (c[3] && a == 8'h00);
    endfunction : addr_hit

    // ==========================================
    // compare and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    // ==========================================
    // stimulus tasks
    task automatic cfg_write(input logic [7:0] w, input logic p, input logic [3:0] f);
        @(posedge mclk_i);
        cfg_in <= w;
        peripheral_enable_i <= p;
        noise_filter_length_i <= f;
        cfg_we_i <= 1'b1;
        @(posedge mclk_i);
        cfg_we_i <= 1'b0;
        cfg_exp = next_cfg(cfg_exp, w, p, f);
        @(negedge mclk_i);
        check(cfg_rb, cfg_exp);
        check(min_rb, cfg_exp & 8'h0B);
        @(negedge mclk_i);
        check(alert_pin_oe_n_o, !(cfg_exp[6] && !cfg_exp[4]));
        check(alert_pin_o, 0);
        check(alert_gpio_free_o, !cfg_exp[6]);
        check(alert_input_en_o, cfg_exp[6] && cfg_exp[4]);
        for (j = 0; j < 9; j++) begin
            @(posedge mclk_i);
            addr_byte_i <= probes[j];
            @(posedge mclk_i);
            @(negedge mclk_i);
            check(addr_match_o, addr_hit(cfg_exp, probes[j]));
        end
    endtask : cfg_write
    task automatic push(input logic [7:0] b);
        @(posedge mclk_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= b;
        do @(posedge mclk_i); while (tx_ready_o !== 1'b1);
        tx_valid_i <= 1'b0;
    endtask : push
    // mode 0 byte already queued, 1 push first, 2 push while stretched
    task automatic run_seq(input logic [3:0] p, h, s, f, input logic [7:0] b, input int mode);
        int n;
        int lo;
        if (mode == 1) push(b);
        @(posedge mclk_i);
        timing_prescaler_i <= p;
        hold_delay_count_i <= h;
        setup_delay_count_i <= s;
        noise_filter_length_i <= f;
        fall_req <= 1'b1;
        @(posedge mclk_i);
        fall_req <= 1'b0;
        n = 0;
        lo = 2 + f + h * (p + 1);
        if (mode == 2) begin
            repeat (20) @(negedge mclk_i);
            check({data_driven_o, scl_oe_n_o, scl_o}, 3'b000);
            push(b);
            lo = 0;
        end
        while (data_driven_o !== 1'b1 && n < 80) begin
            @(negedge mclk_i);
            n++;
        end
        check(n >= lo && n <= lo + 4, 1);
        check({tx_byte_o, sda_o}, {b, b[7]});
        n = 0;
        while (setup_done_o !== 1'b1 && n < 80) begin
            @(negedge mclk_i);
            n++;
            if (setup_done_o !== 1'b1) check(scl_oe_n_o, 0);
        end
        check(n >= (s + 1) * (p + 1) && n <= (s + 1) * (p + 1) + 1, 1);
        repeat (60) @(posedge mclk_i);
    endtask : run_seq

    // ==========================================
    // main sequence
    initial begin
        seed = 22;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(negedge mclk_i);
        check(cfg_rb, 8'h00);
        check({alert_pin_oe_n_o, scl_oe_n_o, sda_oe_n_o, tx_ready_o, addr_match_o}, 5'h1E);
        cfg_write(8'hFF, 1'b0, 4'h0);
        cfg_write(8'h00, 1'b1, 4'h3);
        cfg_write(8'h04, 1'b0, 4'h3);
        cfg_write(8'h40, 1'b0, 4'h0);
        for (i = 0; i < 12; i++) begin
            @(posedge mclk_i);
            slave_role_i <= i[0];
            cfg_write(8'($random(seed)) & {6'h3F, i[0], 1'b1}, i[1],
                4'($random(seed)) & 4'h3);
        end
        cfg_write(8'h00, 1'b0, 4'h0);
        b0 = 8'($random(seed));
        push(b0);
        push(~b0);
        @(posedge mclk_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= 8'h5A;
        @(negedge mclk_i);
        check(tx_ready_o, 0);
        @(posedge mclk_i);
        tx_valid_i <= 1'b0;
        run_seq(4'h1, 4'h2, 4'h1, 4'h0, b0, 0);
        run_seq(4'h0, 4'h0, 4'h0, 4'h1, ~b0, 0);
        @(negedge mclk_i);
        check(tx_ready_o, 1);
        run_seq(4'h0, 4'h1, 4'h3, 4'h0, 8'hC3, 2);
        for (i = 0; i < 8; i++) begin
            run_seq(4'($random(seed)) & 4'h3, 4'($random(seed)) & 4'h3,
                4'($random(seed)) & 4'h3, 4'($random(seed)) & 4'h1, 8'($random(seed)), 1);
        end
        print_verdict();
    end
endmodule : i2c_data_timing_and_address_accept_test
`default_nettype wire
